// ---- src/ptlt_top.sv ----
// top of the pseudo-ternary line transcoder: pin sampling, decoder, checks, alarm
// assumes all inputs are asynchronous pins, slow against the 125 MHz CLOCK
//
// How it works
// - ami: zero is no pulse, ones alternate
// - b6zs replaces six zeros by polarity pattern
// - b8zs replaces eight zeros by polarity pattern
// - hdb3 replaces four zeros by polarity, parity
// - hdb3 violation fourth place, alternating polarity
// - each mark lasts half the bit
// - nrz in becomes two unipolar rz outputs
// - two rz inputs decoded back to nrz
// - encode and decode paths run independently
// - foreign violation pulses error, passes as one
// - excess zero run pulses error one cycle
// - both inputs high: one out, error
// - two low-zero windows in row set alarm
// - window with three zeros clears alarm
// - loopback feeds encoder outputs into decoder
// - outputs run, held zero, or forced ones
// - two pins select the line code
// - sample data falling, launch rising encode edge
// - pulse lasts the encode clock high phase
// - decoder samples and updates on rising edge
`timescale 1ns/10ps
`include "ptlt_regs.svh"

module ptlt_top (
	// system
	input  wire logic CLOCK,
	input  wire logic NRST,
	// encoder side pins
	input  wire logic ENCODE_CLOCK,
	input  wire logic NRZ_IN,
	output wire logic POS_PULSE_OUT,
	output wire logic NEG_PULSE_OUT,
	// decoder side pins
	input  wire logic DECODE_CLOCK,
	input  wire logic POS_PULSE_RX,
	input  wire logic NEG_PULSE_RX,
	output wire logic NRZ_OUT,
	output wire logic ERROR_OUT,
	// alarm
	input  wire logic ALARM_WINDOW,
	output wire logic ALL_ONES_ALARM,
	// controls
	input  wire logic CODE_SELECT_A,
	input  wire logic CODE_SELECT_B,
	input  wire logic OUTPUT_ENABLE,
	input  wire logic FORCE_ALL_ONES,
	input  wire logic LOOPBACK_ENABLE
);
	import ptlt_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [`PTLT_PIN_W-1:0] pins;          // raw pin vector
	logic [`PTLT_PIN_W-1:0] sync1_reg;     // first stage, read by sync2 only
	logic [`PTLT_PIN_W-1:0] sync2_reg;     // second stage
	logic [`PTLT_PIN_W-1:0] sync3_reg;     // third stage
	logic [`PTLT_PIN_W-1:0] lvl_reg;       // accepted pin levels
	logic [`PTLT_PIN_W-1:0] lvl_prev_reg;  // levels one cycle earlier
	logic                   enc_rise;      // encode clock rising
	logic                   enc_fall;      // encode clock falling
	logic                   dec_rise;      // decode clock rising
	logic                   win_rise;      // alarm window period boundary
	ptlt_code_e             code;          // selected line code
	ptlt_omode_e            omode;         // encoder output control
	ptlt_sym_s              enc_sym;       // encoder pulse pair
	ptlt_sym_s              rx_sym;        // decoder input after loopback mux
	ptlt_sym_s              raw_reg [`PTLT_DEPTH];  // received symbols
	ptlt_sym_s              raw_next [`PTLT_DEPTH];
	logic [`PTLT_DEPTH-1:0] dat_reg;       // decoded bits beside raw_reg
	logic [`PTLT_DEPTH-1:0] dat_next;
	logic                   dep_pos_reg;   // polarity of last mark that left the line
	logic                   dep_pos_next;
	logic [3:0]             zc_reg;        // received zero run, saturating
	logic [3:0]             zc_next;
	logic                   err_next;      // error decision for this sample
	logic                   nrz_reg;       // serial output
	logic                   err_reg;       // error output
	logic [1:0]             wz_reg;        // zeros in current window, saturating at three
	logic                   low_prev_reg;  // previous window had fewer than three zeros
	logic                   alarm_reg;     // all-ones alarm output

	assign pins = {CODE_SELECT_B, CODE_SELECT_A, LOOPBACK_ENABLE, FORCE_ALL_ONES, OUTPUT_ENABLE,
	               ALARM_WINDOW, NEG_PULSE_RX, POS_PULSE_RX, NRZ_IN, DECODE_CLOCK, ENCODE_CLOCK};

	// ----------------------------------------------------------------
	// pin sampling: three stages, a change counts when stages two and three agree
	// ----------------------------------------------------------------
	// sampling stages run through reset so that they hold the pin levels when it ends
	always_ff @(posedge CLOCK) begin
		sync1_reg <= pins;
		sync2_reg <= sync1_reg;
		sync3_reg <= sync2_reg;
	end

	// accepted levels start from the pins themselves: no false edge from an idle-high pin
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			lvl_reg      <= sync3_reg;
			lvl_prev_reg <= sync3_reg;
		end else begin
			lvl_reg      <= (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & lvl_reg);
			lvl_prev_reg <= lvl_reg;
		end
	end

	// edge enables from accepted levels
	assign enc_rise = lvl_reg[`PTLT_PIN_ENCODE_CLOCK] & ~lvl_prev_reg[`PTLT_PIN_ENCODE_CLOCK];
	assign enc_fall = ~lvl_reg[`PTLT_PIN_ENCODE_CLOCK] & lvl_prev_reg[`PTLT_PIN_ENCODE_CLOCK];
	assign dec_rise = lvl_reg[`PTLT_PIN_DECODE_CLOCK] & ~lvl_prev_reg[`PTLT_PIN_DECODE_CLOCK];
	assign win_rise = lvl_reg[`PTLT_PIN_WIN] & ~lvl_prev_reg[`PTLT_PIN_WIN];

	// ----------------------------------------------------------------
	// control decode
	// ----------------------------------------------------------------
	assign code = ptlt_code_e'({lvl_reg[`PTLT_PIN_SELB], lvl_reg[`PTLT_PIN_SELA]});

	// output disable wins over the forced alarm pattern
	always_comb begin
		if (!lvl_reg[`PTLT_PIN_OE])
			omode = OM_HOLD;
		else if (lvl_reg[`PTLT_PIN_FORCE])
			omode = OM_FORCE;
		else
			omode = OM_RUN;
	end

	// ----------------------------------------------------------------
	// encoder, running from encode clock edges only
	// ----------------------------------------------------------------
	ptlt_encoder u_encoder (
		.clk      (CLOCK),
		.nrst     (NRST),
		.sample   (enc_fall),
		.launch   (enc_rise),
		.data_in  (lvl_reg[`PTLT_PIN_NRZ]),
		.code     (code),
		.omode    (omode),
		.line_out (enc_sym)
	);

	assign POS_PULSE_OUT = enc_sym.pos;
	assign NEG_PULSE_OUT = enc_sym.neg;

	// loopback replaces the receive pins; external inputs ignored meanwhile
	assign rx_sym = lvl_reg[`PTLT_PIN_LOOP] ? enc_sym :
	                {lvl_reg[`PTLT_PIN_RXP], lvl_reg[`PTLT_PIN_RXN]};

	// ----------------------------------------------------------------
	// most recent polarity before the newest n slots of the line
	// ----------------------------------------------------------------
	function automatic logic prior_pos(input ptlt_sym_s line [`PTLT_DEPTH], input logic [3:0] n,
	                                   input logic dep);
		prior_pos = dep;
		for (int k = `PTLT_DEPTH - 1; k >= 0; k--)
			if (k >= int'(n) && (line[k].pos || line[k].neg))
				prior_pos = line[k].pos;
	endfunction

	// ----------------------------------------------------------------
	// decoder next state for one sample
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] n;
		logic       p;
		logic       m_odd;
		logic       m_even;
		logic       exit_mark;
		n         = ptlt_run_len(code);
		exit_mark = raw_reg[`PTLT_DEPTH-1].pos | raw_reg[`PTLT_DEPTH-1].neg;
		raw_next[0] = rx_sym;
		for (int k = 1; k < `PTLT_DEPTH; k++)
			raw_next[k] = raw_reg[k-1];
		// both marks at once count as a one
		dat_next     = {dat_reg[`PTLT_DEPTH-2:0], rx_sym.pos | rx_sym.neg};
		dep_pos_next = exit_mark ? raw_reg[`PTLT_DEPTH-1].pos : dep_pos_reg;
		// recognise a substitution ending in the newest slot and remove it
		p      = prior_pos(raw_next, n, dep_pos_next);
		m_odd  = (n != `PTLT_RUN_NONE);
		m_even = (n != `PTLT_RUN_NONE);
		for (int k = 0; k < `PTLT_DEPTH; k++)
			if (k < int'(n)) begin
				m_odd  = m_odd & (raw_next[k] == ptlt_sub_sym(code, k, 1'b0, p));
				m_even = m_even & (raw_next[k] == ptlt_sub_sym(code, k, 1'b1, p));
			end
		if (m_odd | m_even)
			for (int k = 0; k < `PTLT_DEPTH; k++)
				if (k < int'(n))
					dat_next[k] = 1'b0;
		// received zero run, counted at the input
		if (rx_sym.pos | rx_sym.neg)
			zc_next = 4'h0;
		else if (zc_reg != `PTLT_ZC_MAX)
			zc_next = zc_reg + 4'h1;
		else
			zc_next = zc_reg;
		err_next = 1'b0;
		if (rx_sym.pos & rx_sym.neg)
			err_next = 1'b1;
		if (n != `PTLT_RUN_NONE && !(rx_sym.pos | rx_sym.neg) && zc_reg == n)
			err_next = 1'b1;
		// a mark leaving with data still set and same polarity is a foreign violation
		if (exit_mark && dat_reg[`PTLT_DEPTH-1] && raw_reg[`PTLT_DEPTH-1].pos == dep_pos_reg)
			err_next = 1'b1;
	end

	// ----------------------------------------------------------------
	// decoder state and outputs, on the rising decode edge
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			for (int k = 0; k < `PTLT_DEPTH; k++)
				raw_reg[k] <= `PTLT_SYM_RST;
			dat_reg     <= '0;
			dep_pos_reg <= 1'b0;
			zc_reg      <= 4'h0;
			nrz_reg     <= 1'b0;
			err_reg     <= 1'b0;
		end else if (dec_rise) begin
			raw_reg     <= raw_next;
			dat_reg     <= dat_next;
			dep_pos_reg <= dep_pos_next;
			zc_reg      <= zc_next;
			nrz_reg     <= dat_reg[`PTLT_DEPTH-1];
			err_reg     <= err_next;
		end
	end

	assign NRZ_OUT   = nrz_reg;
	assign ERROR_OUT = err_reg;

	// ----------------------------------------------------------------
	// all-ones detector: zeros per alarm window
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			wz_reg       <= 2'h0;
			low_prev_reg <= 1'b0;
			alarm_reg    <= 1'b0;
		end else if (win_rise) begin
			// window ends: judge it, start a new count
			if (wz_reg < `PTLT_ALARM_MIN) begin
				if (low_prev_reg)
					alarm_reg <= 1'b1;
			end else begin
				alarm_reg <= 1'b0;
			end
			low_prev_reg <= (wz_reg < `PTLT_ALARM_MIN);
			// a zero arriving with the boundary opens the new window instead of being lost
			wz_reg       <= {1'b0, dec_rise & ~(rx_sym.pos | rx_sym.neg)};
		end else if (dec_rise && !(rx_sym.pos | rx_sym.neg) && wz_reg != `PTLT_ALARM_MIN) begin
			wz_reg <= wz_reg + 2'h1;
		end
	end

	assign ALL_ONES_ALARM = alarm_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);

	a_pulse_ends_fall: assert property (enc_fall && !enc_rise |=> !POS_PULSE_OUT && !NEG_PULSE_OUT)
		else $error("encoder pulse not cleared at falling edge");
	a_pulse_starts_rise: assert property ($rose(POS_PULSE_OUT) || $rose(NEG_PULSE_OUT) |-> $past(enc_rise))
		else $error("encoder pulse began without a rising encode edge");
	a_pulse_holds_high: assert property ((POS_PULSE_OUT || NEG_PULSE_OUT) && !$past(enc_fall) |->
	                                    $stable(POS_PULSE_OUT) || $past(enc_rise))
		else $error("encoder pulse changed inside the high phase");
	a_hold_forces_zero: assert property (enc_rise && omode == OM_HOLD |=> !POS_PULSE_OUT && !NEG_PULSE_OUT)
		else $error("disabled outputs carried a pulse");
	a_never_both_out: assert property (!(POS_PULSE_OUT && NEG_PULSE_OUT))
		else $error("both encoder outputs high together");
	a_both_rx_error: assert property (dec_rise && rx_sym.pos && rx_sym.neg |=> ERROR_OUT ##0
	                                  (dat_reg[0] throughout (!dec_rise)[*1]))
		else $error("double mark not flagged as a one with error");
	a_excess_zero_err: assert property (dec_rise && code != CODE_AMI && !rx_sym.pos && !rx_sym.neg &&
	                                    zc_reg == ptlt_run_len(code) |=> ERROR_OUT)
		else $error("excess zero run not flagged");
	a_nrz_on_rise: assert property (!$past(dec_rise) |-> $stable(NRZ_OUT) && $stable(ERROR_OUT))
		else $error("decoder output moved without a decode edge");
	a_loop_source: assert property (lvl_reg[`PTLT_PIN_LOOP] |-> rx_sym == enc_sym)
		else $error("loopback not fed from the encoder");
	a_alarm_set: assert property (win_rise && wz_reg < `PTLT_ALARM_MIN && low_prev_reg |=> ALL_ONES_ALARM)
		else $error("all-ones alarm not raised");
	a_alarm_clear: assert property (win_rise && wz_reg == `PTLT_ALARM_MIN |=> !ALL_ONES_ALARM)
		else $error("all-ones alarm not cleared");

	c_error_pulse: cover property (dec_rise && err_next);
	c_alarm_raised: cover property ($rose(ALL_ONES_ALARM));
	c_loop_data: cover property (lvl_reg[`PTLT_PIN_LOOP] && dec_rise && NRZ_OUT);
	c_hdb3_mark: cover property (code == CODE_HDB3 && $rose(NEG_PULSE_OUT));

endmodule // ptlt_top

// ---- include/ptlt_regs.svh ----
// constants of the pseudo-ternary line transcoder: field positions, resets, counts
// assumes nothing; included by the package and by the design modules
`ifndef PTLT_REGS_SVH
`define PTLT_REGS_SVH

// ----------------------------------------------------------------
// code select values (select_b is the high bit)
// ----------------------------------------------------------------
`define PTLT_CODE_AMI   2'h0
`define PTLT_CODE_B6ZS  2'h1
`define PTLT_CODE_B8ZS  2'h2
`define PTLT_CODE_HDB3  2'h3

// ----------------------------------------------------------------
// zero-run lengths that trigger substitution, and depth of the delay lines
// ----------------------------------------------------------------
`define PTLT_RUN_NONE   4'h0
`define PTLT_RUN_B6ZS   4'h6
`define PTLT_RUN_B8ZS   4'h8
`define PTLT_RUN_HDB3   4'h4
`define PTLT_DEPTH      8
`define PTLT_ZC_MAX     4'hF
`define PTLT_ALARM_MIN  2'h3

// ----------------------------------------------------------------
// bit positions inside the pin synchroniser vector
// ----------------------------------------------------------------
`define PTLT_PIN_W      11
`define PTLT_PIN_ENCODE_CLOCK   0
`define PTLT_PIN_DECODE_CLOCK   1
`define PTLT_PIN_NRZ    2
`define PTLT_PIN_RXP    3
`define PTLT_PIN_RXN    4
`define PTLT_PIN_WIN    5
`define PTLT_PIN_OE     6
`define PTLT_PIN_FORCE  7
`define PTLT_PIN_LOOP   8
`define PTLT_PIN_SELA   9
`define PTLT_PIN_SELB   10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PTLT_PINS_RST   11'h000
`define PTLT_SYM_RST    2'h0

`endif

// ---- include/ptlt_pkg.sv ----
// types and shared decoding of the pseudo-ternary line transcoder
// assumes ptlt_regs.svh is on the include path
`include "ptlt_regs.svh"

package ptlt_pkg;

	// line code in use
	typedef enum logic [1:0] {
		CODE_AMI  = `PTLT_CODE_AMI,
		CODE_B6ZS = `PTLT_CODE_B6ZS,
		CODE_B8ZS = `PTLT_CODE_B8ZS,
		CODE_HDB3 = `PTLT_CODE_HDB3
	} ptlt_code_e;

	// encoder output control, one-hot
	typedef enum logic [2:0] {
		OM_RUN   = 3'h1,
		OM_HOLD  = 3'h2,
		OM_FORCE = 3'h4
	} ptlt_omode_e;

	// one ternary symbol as two unipolar marks
	typedef struct packed {
		logic pos;
		logic neg;
	} ptlt_sym_s;

	// zero-run length replaced by the code, none for ami
	function automatic logic [3:0] ptlt_run_len(input ptlt_code_e code);
		case (code)
			CODE_B6ZS: ptlt_run_len = `PTLT_RUN_B6ZS;
			CODE_B8ZS: ptlt_run_len = `PTLT_RUN_B8ZS;
			CODE_HDB3: ptlt_run_len = `PTLT_RUN_HDB3;
			default:   ptlt_run_len = `PTLT_RUN_NONE;
		endcase
	endfunction

	// symbol at position idx (0 = newest) of a substitution; last_pos is the preceding pulse
	function automatic ptlt_sym_s ptlt_sub_sym(input ptlt_code_e code, input int idx,
	                                           input logic even, input logic last_pos);
		ptlt_sym_s same;
		ptlt_sym_s opp;
		same = last_pos ? 2'h2 : 2'h1;
		opp  = last_pos ? 2'h1 : 2'h2;
		ptlt_sub_sym = `PTLT_SYM_RST;
		case (code)
			CODE_B6ZS, CODE_B8ZS: begin
				if (idx == 4 || idx == 0)
					ptlt_sub_sym = same;
				else if (idx == 3 || idx == 1)
					ptlt_sub_sym = opp;
			end
			CODE_HDB3: begin
				if (idx == 0)
					ptlt_sub_sym = even ? opp : same;
				else if (idx == 3 && even)
					ptlt_sub_sym = opp;
			end
			default: ptlt_sub_sym = `PTLT_SYM_RST;
		endcase
	endfunction

endpackage

// ---- src/ptlt_encoder.sv ----
// encoder of the line transcoder: nrz bits in, substituted ternary marks out
// assumes enable pulses for the encode clock edges already synchronised to clk
`timescale 1ns/10ps
`include "ptlt_regs.svh"

module ptlt_encoder (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// encode clock edges and data
	input  wire logic              sample,
	input  wire logic              launch,
	input  wire logic              data_in,
	// controls
	input  wire ptlt_pkg::ptlt_code_e  code,
	input  wire ptlt_pkg::ptlt_omode_e omode,
	// pulse pair toward the line
	output ptlt_pkg::ptlt_sym_s    line_out
);
	import ptlt_pkg::*;

	ptlt_sym_s   pipe_reg [`PTLT_DEPTH];   // symbols waiting, index 7 leaves first
	ptlt_sym_s   pipe_next [`PTLT_DEPTH];
	ptlt_sym_s   out_reg;                  // launched pulse pair
	logic        last_pos_reg;             // polarity of newest mark entered
	logic        last_pos_next;
	logic        parity_reg;               // marks since last substitution, odd
	logic        parity_next;
	logic [3:0]  zrun_reg;                 // zeros since last mark or substitution
	logic [3:0]  zrun_next;
	logic        force_pos_reg;            // polarity of next forced mark

	assign line_out = out_reg;

	// ----------------------------------------------------------------
	// next pipeline contents for one sampled bit
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] n;
		n = ptlt_run_len(code);
		pipe_next[0] = `PTLT_SYM_RST;
		for (int k = 1; k < `PTLT_DEPTH; k++)
			pipe_next[k] = pipe_reg[k-1];
		last_pos_next = last_pos_reg;
		parity_next   = parity_reg;
		zrun_next     = zrun_reg;
		if (data_in) begin
			// a one alternates against the previous mark
			pipe_next[0]  = last_pos_reg ? 2'h1 : 2'h2;
			last_pos_next = ~last_pos_reg;
			parity_next   = ~parity_reg;
			zrun_next     = 4'h0;
		end else if (n != `PTLT_RUN_NONE && zrun_reg + 4'h1 == n) begin
			// run complete: overwrite the last n slots with the pattern
			for (int k = 0; k < `PTLT_DEPTH; k++)
				if (k < int'(n))
					pipe_next[k] = ptlt_sub_sym(code, k, ~parity_reg, last_pos_reg);
			// even hdb3 ends on the opposite polarity, so the next violation alternates
			if (code == CODE_HDB3 && !parity_reg)
				last_pos_next = ~last_pos_reg;
			parity_next = 1'b0;
			zrun_next   = 4'h0;
		end else begin
			// zero inside a run, ami passes it as no pulse
			zrun_next = zrun_reg + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// pipeline and coder state, advanced on the falling encode edge
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int k = 0; k < `PTLT_DEPTH; k++)
				pipe_reg[k] <= `PTLT_SYM_RST;
			last_pos_reg <= 1'b0;
			parity_reg   <= 1'b0;
			zrun_reg     <= 4'h0;
		end else if (sample) begin
			pipe_reg     <= pipe_next;
			last_pos_reg <= last_pos_next;
			parity_reg   <= parity_next;
			zrun_reg     <= zrun_next;
		end
	end

	// ----------------------------------------------------------------
	// output pair: set on the rising edge, cleared on the falling edge
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			out_reg       <= `PTLT_SYM_RST;
			force_pos_reg <= 1'b1;
		end else if (launch) begin
			case (omode)
				OM_RUN:   out_reg <= pipe_reg[`PTLT_DEPTH-1];
				OM_HOLD:  out_reg <= `PTLT_SYM_RST;
				OM_FORCE: begin
					// all-ones alarm pattern as alternating marks
					out_reg       <= force_pos_reg ? 2'h2 : 2'h1;
					force_pos_reg <= ~force_pos_reg;
				end
				default:  out_reg <= `PTLT_SYM_RST;
			endcase
		end else if (sample) begin
			out_reg <= `PTLT_SYM_RST;
		end
	end

endmodule // ptlt_encoder

// ---- testbench/ptlt_line_model.sv ----
// line splitter model: hands the encoder marks back to the receive pins
// assumes the bench drives inj_en and inj_sym just after a clock edge
`timescale 1ns/10ps

module ptlt_line_model (
	// marks from the transmitter
	input  wire logic       tx_pos,
	input  wire logic       tx_neg,
	// symbol forced onto the line by the bench
	input  wire logic       inj_en,
	input  wire logic [1:0] inj_sym,
	// comparator outputs toward the receiver
	output wire logic       rx_pos,
	output wire logic       rx_neg
);
	// comparators sit low on a quiet line; injection overrides the looped marks
	assign rx_pos = inj_en ? inj_sym[1] : tx_pos;
	assign rx_neg = inj_en ? inj_sym[0] : tx_neg;
endmodule // ptlt_line_model

// ---- testbench/ptlt_top_tb_top.sv ----
// bench of the line transcoder: codes, decode, errors, alarm, loopback, output controls
// assumes the line model is compiled first and the design sources are on the path
`timescale 1ns/10ps

module ptlt_top_tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic       clk, nrst, enc_clk, nrz_in, dec_clk, win, oe, force_on, loop_en, inj_en;
	logic [1:0] sel, inj_sym;
	wire logic  pos, neg, rx_p, rx_n, nrz_out, err, alarm;
	int         n_mismatch = 0, compares = 0;
	int         stim[$], xs[$], eq[$];          // stimulus, expected and seen line symbols
	logic       dq[$], xq[$];                   // seen nrz and error per decode period
	localparam logic [39:0] PAT = 40'h4030810041; // runs of 8, 4, 6, 9 and 5 zeros

	ptlt_top dut (.CLOCK(clk), .NRST(nrst), .ENCODE_CLOCK(enc_clk), .NRZ_IN(nrz_in),
		.POS_PULSE_OUT(pos), .NEG_PULSE_OUT(neg), .DECODE_CLOCK(dec_clk), .POS_PULSE_RX(rx_p),
		.NEG_PULSE_RX(rx_n), .NRZ_OUT(nrz_out), .ERROR_OUT(err), .ALARM_WINDOW(win),
		.ALL_ONES_ALARM(alarm), .CODE_SELECT_A(sel[0]), .CODE_SELECT_B(sel[1]),
		.OUTPUT_ENABLE(oe), .FORCE_ALL_ONES(force_on), .LOOPBACK_ENABLE(loop_en));
	ptlt_line_model u_line (.tx_pos(pos), .tx_neg(neg), .inj_en(inj_en), .inj_sym(inj_sym),
		.rx_pos(rx_p), .rx_neg(rx_n));

	// 125 MHz system clock
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic rst;
		nrst = 0;
		sel = 2'h0;
		inj_sym = 2'h0;
		w(16);
		nrst = 1;
		w(8);
	endtask

	// alternating marks, first positive
	task automatic alt(input int n);
		for (int i = 0; i < n; i++)
			stim.push_back(i % 2 ? -1 : 1);
	endtask

	// one bit period of 24 clocks: both link clocks, data or injected symbol, window pin
	task automatic bit_per(input int s, input int idx);
		nrz_in = (s != 0);
		win = (idx % 6 == 0);
		w(4);
		dq.push_back(nrz_out);
		xq.push_back(err);
		w(2);
		enc_clk = 0;
		dec_clk = 0;
		win = 0;
		w(6);
		check("rz_low", {pos, neg}, 8'h00);
		w(2);
		enc_clk = 1;
		inj_sym = {s > 0, s < 0 || s == 2};
		w(6);
		eq.push_back({pos, neg} === 2'h2 ? 1 : {pos, neg} === 2'h1 ? -1 : {pos, neg} === 2'h0 ? 0 : 2);
		w(2);
		dec_clk = 1;
		w(2);
	endtask

	task automatic run(input logic inj);
		eq.delete();
		dq.delete();
		xq.delete();
		inj_en = inj;
		foreach (stim[i])
			bit_per(stim[i], i);
	endtask

	// expected line symbols of the 39 pattern bits for the selected code
	task automatic model;
		int lp, par, zr, n;
		lp = -1;
		par = 0;
		zr = 0;
		n = sel == 2'h0 ? 99 : sel == 2'h3 ? 4 : 4 + 2 * sel;
		xs.delete();
		for (int k = 0; k < 39; k++) begin
			xs.push_back(0);
			zr = stim[k] ? 0 : zr + 1;
			if (stim[k]) begin
				lp = -lp;
				par ^= 1;
				xs[k] = lp;
			end else if (zr == n) begin
				zr = 0;
				if (n == 4) begin
					if (!par) begin
						lp = -lp;
						xs[k-3] = lp;
					end
					par = 0;
				end else begin
					xs[k-4] = lp;
					xs[k-3] = -lp;
					xs[k-1] = -lp;
				end
				xs[k] = lp;
			end
		end
	endtask

	task automatic pat(input logic [1:0] c);
		rst();
		sel = c;
		stim.delete();
		for (int k = 38; k >= 0; k--)
			stim.push_back(PAT[k]);
		repeat (20) stim.push_back(0);
		model();
	endtask

	// align at the first mark and first decoded one, then compare
	task automatic cmp(input int nb, input int nerr, input bit es);
		int f, g, e;
		f = 0;
		g = 0;
		e = 0;
		while (f < eq.size() && eq[f] == 0) f++;
		while (g < dq.size() && dq[g] !== 1'b1) g++;
		for (int i = 0; i < nb; i++) begin
			if (es) check("line_sym", eq[f+i], xs[i]);
			check("nrz_out", dq[g+i], stim[i] != 0);
		end
		foreach (xq[i])
			if (i >= (es ? g : 0) && xq[i] !== 1'b0) e++;
		check("err_count", e, nerr);
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{nrz_in, dec_clk, win, sel, force_on, loop_en, inj_en, inj_sym, nrst} = '0;
		{enc_clk, oe} = 2'h3;
		rst();
		check("idle", {pos, neg, nrz_out, err, alarm}, 8'h00);
		// every code over the line, then hdb3 in loopback with the rx pins jammed
		for (int c = 0; c < 5; c++) begin
			loop_en = (c == 4);
			pat(c == 4 ? 2'h3 : 2'(c));
			run(c == 4);
			cmp(39, 0, 1);
		end
		loop_en = 0;
		// foreign violation and both marks high, ami
		rst();
		stim = '{1, -1, 1, 1, -1, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
		run(1);
		cmp(6, 2, 0);
		// one zero past the longest run of each substituting code
		for (int c = 1; c < 4; c++) begin
			rst();
			sel = 2'(c);
			stim = '{1};
			repeat (c == 3 ? 5 : 5 + 2 * c) stim.push_back(0);
			stim.push_back(-1);
			alt(12);
			run(1);
			cmp(c == 3 ? 7 : 7 + 2 * c, 1, 0);
		end
		// all marks over several windows, then a window with zeros
		rst();
		stim.delete();
		alt(24);
		run(1);
		check("alarm_set", alarm, 1'b1);
		stim = '{1, 0, 0, 0, -1, 0};
		alt(10);
		run(1);
		check("alarm_clear", alarm, 1'b0);
		// disabled outputs beat force, then forced marks alternate
		pat(2'h0);
		oe = 0;
		force_on = 1;
		run(0);
		foreach (eq[i])
			check("held_zero", eq[i], 8'h00);
		oe = 1;
		stim.delete();
		repeat (16) stim.push_back(0);
		run(0);
		for (int i = 8; i < 16; i++)
			check("forced_ones", eq[i] * eq[i-1], 8'hFF);
		end_sim();
	end

	// watchdog well beyond the run length
	initial begin
		#600000;
		n_mismatch++;
		end_sim();
	end
endmodule // ptlt_top_tb_top
